// ===== hw/icar_arbiter.sv
/*
  IDE channel arbiter with drive reset buffer and interrupt routing.
  Assumes all inputs are synchronous to mclk and that decode and DMA
  request levels are held until the access or transfer ends.
*/
`timescale 1ns/100ps
`default_nettype none
module icar_arbiter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire icar_pkg::icar_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  input wire logic [1:0] pio_dec,
  input wire logic [1:0] drq,
  input wire logic [1:0] fifo_nonempty,
  input wire logic bm_mem_req,
  input wire logic [1:0] drive_irq,
  input wire logic [3:0] isa_irq_in,
  output logic [1:0] data_grant,
  output logic [1:0] addr_grant,
  output logic [1:0] dack_en,
  output logic [1:0] pci_retry,
  output logic [1:0] flush_req,
  output logic [1:0] delayed_txn,
  output logic bm_grant,
  output logic ide_reset_n,
  output logic [3:0] isa_irq_out,
  output logic [1:0] native_irq_source
);
  icar_pkg::icar_state_t state, next_state, pick;
  logic [7:0] mode_reg, route_reg, next_mode, next_route;
  logic [7:0] ch_cfg [2];
  logic [7:0] next_ch_cfg [2];
  logic [7:0] next_rdata;
  logic [1:0] next_dgrant, next_agrant, next_dack, next_retry;
  logic [1:0] next_flush, next_delayed, next_native;
  logic [1:0] route_sel [2];
  logic [1:0] nat_mode;
  logic [3:0] next_irq;
  logic next_bm, next_drst_n;

  // Fixed-priority pick used whenever the bus is re-arbitrated.
  always_comb
  begin
    if (pio_dec[0]) pick = icar_pkg::ST_PIO0;
    else if (pio_dec[1]) pick = icar_pkg::ST_PIO1;
    else if (drq[0]) pick = icar_pkg::ST_DMA0;
    else if (drq[1]) pick = icar_pkg::ST_DMA1;
    else pick = icar_pkg::ST_IDLE;
  end

  // Grant state: holds until completion or a revoking PIO request.
  always_comb
  begin
    next_state = state;
    unique case (state)
      icar_pkg::ST_IDLE: next_state = pick;
      icar_pkg::ST_PIO0:
        if (!pio_dec[0]) next_state = pick;
      icar_pkg::ST_PIO1:
        if (pio_dec[0]) next_state = icar_pkg::ST_PIO0;
        else if (!pio_dec[1]) next_state = pick;
      icar_pkg::ST_DMA0:
        if (pio_dec[1]) next_state = icar_pkg::ST_PIO1;
        else if (!drq[0]) next_state = pick;
      icar_pkg::ST_DMA1:
        if (pio_dec[0]) next_state = icar_pkg::ST_PIO0;
        else if (!drq[1]) next_state = pick;
    endcase
  end

  // Bus steering, retry, flush and acknowledge, aligned with the state.
  always_comb
  begin
    next_agrant = {next_state == icar_pkg::ST_PIO1,
                   next_state == icar_pkg::ST_PIO0};
    next_dgrant = next_agrant | {next_state == icar_pkg::ST_DMA1,
                                 next_state == icar_pkg::ST_DMA0};
    next_bm = (next_state == icar_pkg::ST_IDLE) && bm_mem_req;
    next_flush = pio_dec & fifo_nonempty;
    // Acknowledge is withheld while that channel's FIFO is flushing.
    next_dack = next_dgrant & ~next_agrant & drq & ~next_flush;
    // Retry unless the channel owns the bus, FIFO empty, no DACK on.
    next_retry = pio_dec & (fifo_nonempty | {2{|dack_en}}
                 | ~next_agrant);
    next_delayed[0] = (state == icar_pkg::ST_DMA1)
                      && (next_state == icar_pkg::ST_PIO0);
    next_delayed[1] = (state == icar_pkg::ST_DMA0)
                      && (next_state == icar_pkg::ST_PIO1);
    next_drst_n = !ch_cfg[0][icar_pkg::CH_DRV_RST];
  end

  // Legacy routing code to IRQ line index, per channel.
  always_comb
  begin
    unique case (route_reg[icar_pkg::RT0_LSB +: 2])
      2'h0: route_sel[0] = icar_pkg::IRQ14;
      2'h1: route_sel[0] = icar_pkg::IRQ15;
      2'h2: route_sel[0] = icar_pkg::IRQ10;
      2'h3: route_sel[0] = icar_pkg::IRQ11;
    endcase
    unique case (route_reg[icar_pkg::RT1_LSB +: 2])
      2'h0: route_sel[1] = icar_pkg::IRQ15;
      2'h1: route_sel[1] = icar_pkg::IRQ14;
      2'h2: route_sel[1] = icar_pkg::IRQ10;
      2'h3: route_sel[1] = icar_pkg::IRQ11;
    endcase
    nat_mode = {mode_reg[icar_pkg::MODE_NAT1],
                mode_reg[icar_pkg::MODE_NAT0]};
  end

  // Per-channel native output and per-line legacy merge.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_line
      always_comb
      begin
        next_irq[g] = isa_irq_in[g];
        for (int c = 0; c < 2; c++)
          if (!nat_mode[c] && ch_cfg[c][icar_pkg::CH_IRQ_EN]
              && route_sel[c] == 2'(g))
            next_irq[g] = isa_irq_in[g] | drive_irq[c];
      end
    end
    for (g = 0; g < 2; g++)
    begin : g_chan
      always_comb
      begin
        // Legacy source leaves the native output quiet.
        next_native[g] = nat_mode[g] && ch_cfg[g][icar_pkg::CH_IRQ_EN]
                         && drive_irq[g]
                         && isa_irq_in[route_sel[g]];
      end
    end
  endgenerate

  // Configuration writes and registered reads; unmapped reads give zero.
  always_comb
  begin
    next_mode = mode_reg;
    next_route = route_reg;
    next_ch_cfg = ch_cfg;
    next_rdata = cfg_rdata;
    if (cfg_req.wr && cfg_req.func == icar_pkg::FUNC_IDE)
    begin
      if (cfg_req.offset == icar_pkg::OFS_MODE)
        next_mode = cfg_req.wdata;
      if (cfg_req.offset == icar_pkg::OFS_CH0)
        next_ch_cfg[0] = cfg_req.wdata;
      if (cfg_req.offset == icar_pkg::OFS_CH1)
        next_ch_cfg[1] = cfg_req.wdata;
    end
    if (cfg_req.wr && cfg_req.func == icar_pkg::FUNC_BRIDGE
        && cfg_req.offset == icar_pkg::OFS_ROUTE)
      next_route = cfg_req.wdata;
    if (cfg_req.rd)
    begin
      next_rdata = 8'h00;
      if (cfg_req.func == icar_pkg::FUNC_IDE)
        unique case (cfg_req.offset)
          icar_pkg::OFS_MODE: next_rdata = mode_reg;
          icar_pkg::OFS_CH0: next_rdata = ch_cfg[0];
          icar_pkg::OFS_CH1: next_rdata = ch_cfg[1];
          default: next_rdata = 8'h00;
        endcase
      else if (cfg_req.func == icar_pkg::FUNC_BRIDGE
               && cfg_req.offset == icar_pkg::OFS_ROUTE)
        next_rdata = route_reg;
    end
  end

  // All state and outputs register here; drive reset is low in reset.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= icar_pkg::ST_IDLE;
      mode_reg <= icar_pkg::MODE_RST;
      route_reg <= icar_pkg::ROUTE_RST;
      ch_cfg[0] <= icar_pkg::CHCFG_RST;
      ch_cfg[1] <= icar_pkg::CHCFG_RST;
      cfg_rdata <= 8'h00;
      data_grant <= 2'h0;
      addr_grant <= 2'h0;
      dack_en <= 2'h0;
      pci_retry <= 2'h0;
      flush_req <= 2'h0;
      delayed_txn <= 2'h0;
      bm_grant <= 1'b0;
      ide_reset_n <= 1'b0;
      isa_irq_out <= 4'h0;
      native_irq_source <= 2'h0;
    end
    else
    begin
      state <= next_state;
      mode_reg <= next_mode;
      route_reg <= next_route;
      ch_cfg <= next_ch_cfg;
      cfg_rdata <= next_rdata;
      data_grant <= next_dgrant;
      addr_grant <= next_agrant;
      dack_en <= next_dack;
      pci_retry <= next_retry;
      flush_req <= next_flush;
      delayed_txn <= next_delayed;
      bm_grant <= next_bm;
      ide_reset_n <= next_drst_n;
      isa_irq_out <= next_irq;
      native_irq_source <= next_native;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_dma0_held;
    state == icar_pkg::ST_DMA0 && drq[0] && !pio_dec[1];
  endsequence
  sequence s_dma1_cut;
    state == icar_pkg::ST_DMA1 && pio_dec[0];
  endsequence

  property p_first_wins;
    state == icar_pkg::ST_IDLE && pio_dec == 2'h0 && drq == 2'h2
      |=> state == icar_pkg::ST_DMA1 && data_grant == 2'h2;
  endproperty
  a_first_wins: assert property (p_first_wins)
    else $error("idle bus not given to requester");
  property p_hold;
    s_dma0_held |=> state == icar_pkg::ST_DMA0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("DMA grant lost without cause");
  property p_steer;
    drq[0] && pio_dec == 2'h0 && state != icar_pkg::ST_DMA1
      |=> data_grant == 2'h1 && addr_grant == 2'h0;
  endproperty
  a_steer: assert property (p_steer)
    else $error("DMA steering wrong");
  property p_fifo_retry;
    pio_dec[0] && fifo_nonempty[0] |=> pci_retry[0] && flush_req[0]
      && !dack_en[0];
  endproperty
  a_fifo_retry: assert property (p_fifo_retry)
    else $error("PIO not retried or flushed");
  property p_rearb;
    state == icar_pkg::ST_DMA0 && !drq[0] && pio_dec == 2'h0 && drq[1]
      |=> state == icar_pkg::ST_DMA1;
  endproperty
  a_rearb: assert property (p_rearb)
    else $error("no rearbitration on request drop");
  property p_same_ch;
    state == icar_pkg::ST_DMA0 && pio_dec == 2'h1 && drq[0]
      |=> state == icar_pkg::ST_DMA0 && pci_retry[0];
  endproperty
  a_same_ch: assert property (p_same_ch)
    else $error("same-channel PIO not retried");
  property p_cut;
    s_dma1_cut |=> state == icar_pkg::ST_PIO0 && delayed_txn[0]
      && dack_en == 2'h0 ##1 !delayed_txn[0];
  endproperty
  a_cut: assert property (p_cut)
    else $error("DMA grant not removed");
  property p_drv_reset;
    ch_cfg[0][icar_pkg::CH_DRV_RST] |=> !ide_reset_n;
  endproperty
  a_drv_reset: assert property (p_drv_reset)
    else $error("drive reset not driven low");
  property p_legacy_quiet;
    !nat_mode[0] |=> !native_irq_source[0];
  endproperty
  a_legacy_quiet: assert property (p_legacy_quiet)
    else $error("native interrupt active in legacy mode");
  property p_no_grant;
    pio_dec == 2'h0 && drq == 2'h0
      |=> data_grant == 2'h0 && addr_grant == 2'h0 && dack_en == 2'h0;
  endproperty
  a_no_grant: assert property (p_no_grant)
    else $error("grant held with no request");

  // Priority, configuration writes and interrupt paths, checked on outputs and registers.
  property p_pio_first;
    pio_dec[0] && state != icar_pkg::ST_DMA0
      |=> data_grant == 2'h1 && addr_grant == 2'h1;
  endproperty
  a_pio_first: assert property (p_pio_first)
    else $error("primary PIO not given both buses");
  property p_bm_last;
    bm_mem_req && (pio_dec != 2'h0 || drq != 2'h0) |=> !bm_grant;
  endproperty
  a_bm_last: assert property (p_bm_last)
    else $error("bus master granted over an IDE request");
  property p_mode_write;
    cfg_req.wr && cfg_req.func == icar_pkg::FUNC_IDE
      && cfg_req.offset == icar_pkg::OFS_MODE
      |=> mode_reg == $past(cfg_req.wdata);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode register write lost");
  property p_ch1_write;
    cfg_req.wr && cfg_req.func == icar_pkg::FUNC_IDE
      && cfg_req.offset == icar_pkg::OFS_CH1
      |=> ch_cfg[1] == $past(cfg_req.wdata);
  endproperty
  a_ch1_write: assert property (p_ch1_write)
    else $error("secondary channel register write lost");
  property p_legacy_route;
    !nat_mode[0] && ch_cfg[0][icar_pkg::CH_IRQ_EN] && drive_irq[0]
      && route_reg[icar_pkg::RT0_LSB +: 2] == 2'h0
      |=> isa_irq_out[icar_pkg::IRQ14];
  endproperty
  a_legacy_route: assert property (p_legacy_route)
    else $error("primary interrupt not on its default line");
  property p_native_and;
    nat_mode[0] && ch_cfg[0][icar_pkg::CH_IRQ_EN]
      && route_reg[icar_pkg::RT0_LSB +: 2] == 2'h2
      |=> native_irq_source[0]
        == ($past(drive_irq[0]) && $past(isa_irq_in[icar_pkg::IRQ10]));
  endproperty
  a_native_and: assert property (p_native_and)
    else $error("native interrupt not gated by the routed line");
  property p_irq_pass;
    !ch_cfg[0][icar_pkg::CH_IRQ_EN] && !ch_cfg[1][icar_pkg::CH_IRQ_EN]
      |=> isa_irq_out == $past(isa_irq_in);
  endproperty
  a_irq_pass: assert property (p_irq_pass)
    else $error("IRQ lines altered with interrupts disabled");
endmodule
`default_nettype wire

// ===== pkg/icar_pkg.sv
/*
  Constants and types for the IDE channel arbiter and interrupt router.
  Assumes a single 100 MHz clock and byte-wide configuration accesses.
*/
package icar_pkg;
  localparam logic [2:0] FUNC_IDE = 3'h1;
  localparam logic [2:0] FUNC_BRIDGE = 3'h0;
  localparam logic [7:0] OFS_MODE = 8'h09;
  localparam logic [7:0] OFS_ROUTE = 8'h4a;
  localparam logic [7:0] OFS_CH0 = 8'h10;
  localparam logic [7:0] OFS_CH1 = 8'h18;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] CHCFG_RST = 8'h01;
  // Native-mode bits of the mode register, per channel.
  localparam int MODE_NAT0 = 0;
  localparam int MODE_NAT1 = 2;
  // Channel configuration bits.
  localparam int CH_IRQ_EN = 0;
  localparam int CH_DRV_RST = 1;
  // Routing fields and IRQ line indexes.
  localparam int RT0_LSB = 0;
  localparam int RT1_LSB = 2;
  localparam logic [1:0] IRQ10 = 2'h0;
  localparam logic [1:0] IRQ11 = 2'h1;
  localparam logic [1:0] IRQ14 = 2'h2;
  localparam logic [1:0] IRQ15 = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PIO0 = 5'h02,
    ST_PIO1 = 5'h04,
    ST_DMA0 = 5'h08,
    ST_DMA1 = 5'h10
  } icar_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] func;
    logic [7:0] offset;
    logic [7:0] wdata;
  } icar_cfg_req_t;
endpackage

// ===== test/icar_drive_model.sv
/*
  Model of the drives that sit on the two IDE channels.
  Assumes the bench commands the request and interrupt level per channel.
*/
`timescale 1ns/100ps
`default_nettype none
module icar_drive_model (
  input wire logic mclk,
  input wire logic [1:0] dma_cmd,
  input wire logic [1:0] irq_cmd,
  output logic [1:0] drq = 2'h0,
  output logic [1:0] drive_irq = 2'h0
);
  // A drive changes its levels one clock after it is told to.
  always @(posedge mclk)
  begin
    drq <= dma_cmd;
    drive_irq <= irq_cmd;
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
  Self-checking bench for the IDE channel arbiter and interrupt router.
  Assumes the drive model is compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  icar_pkg::icar_cfg_req_t cfg_req = '0;
  logic [1:0] pio_dec = 2'h0;
  logic [1:0] fifo_nonempty = 2'h0;
  logic bm_mem_req = 1'b0;
  logic [3:0] isa_irq_in = 4'h0;
  logic [1:0] dma_cmd = 2'h0;
  logic [1:0] irq_cmd = 2'h0;
  logic [7:0] cfg_rdata;
  logic [1:0] drq, drive_irq, data_grant, addr_grant, dack_en;
  logic [1:0] pci_retry, flush_req, delayed_txn, native_irq_source;
  logic bm_grant, ide_reset_n, rd_pend;
  logic [3:0] isa_irq_out, r;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int tests_run = 0;

  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  icar_drive_model i_drv (.mclk, .dma_cmd, .irq_cmd, .drq, .drive_irq);

  icar_arbiter i_dut (.mclk, .reset_n, .cfg_req, .cfg_rdata, .pio_dec,
    .drq, .fifo_nonempty, .bm_mem_req, .drive_irq, .isa_irq_in,
    .data_grant, .addr_grant, .dack_en, .pci_retry, .flush_req,
    .delayed_txn, .bm_grant, .ide_reset_n, .isa_irq_out,
    .native_irq_source);

  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One configuration write or read; a read notes its expected byte.
  task automatic cfg(input logic w, input logic [2:0] f,
    input logic [7:0] o, input logic [7:0] d);
    @(posedge mclk);
    cfg_req <= '{wr: w, rd: !w, func: f, offset: o, wdata: d};
    if (!w)
      exp_q.push_back(d);
    @(posedge mclk);
    cfg_req <= '0;
  endtask

  // Read answers are compared with the oldest note once they settle.
  always @(posedge mclk)
  begin
    rd_pend = cfg_req.rd;
    #1;
    if (rd_pend)
      check("cfg_rdata", cfg_rdata, exp_q.pop_front());
  end

  // A hung run is cut short and counted as a mismatch.
  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  // Main sequence of scenarios.
  initial
  begin
    void'($urandom(32'h8612));
    r = 4'($urandom);
    tick(7);
    check("ide_reset_n", 8'(ide_reset_n), 8'h00);
    @(posedge mclk);
    reset_n <= 1'b1;
    tick(1);
    check("grant_idle", 8'(data_grant), 8'h00);
    cfg(1'b0, 3'h1, 8'h09, 8'h00);
    cfg(1'b0, 3'h0, 8'h4a, 8'h00);
    cfg(1'b0, 3'h1, 8'h18, 8'h01);
    cfg(1'b0, 3'h1, 8'h30, 8'h00);
    @(posedge mclk);
    bm_mem_req <= 1'b1;
    tick(1);
    check("bm_grant", 8'(bm_grant), 8'h01);
    @(posedge mclk);
    dma_cmd <= 2'h1;
    tick(2);
    check("data_grant", 8'(data_grant), 8'h01);
    check("addr_grant", 8'(addr_grant), 8'h00);
    check("dack_en", 8'(dack_en), 8'h01);
    check("bm_busy", 8'(bm_grant), 8'h00);
    @(posedge mclk);
    pio_dec <= 2'h2;
    tick(1);
    check("data_grant", 8'(data_grant), 8'h02);
    check("addr_grant", 8'(addr_grant), 8'h02);
    check("delayed_txn", 8'(delayed_txn), 8'h02);
    check("pci_retry", 8'(pci_retry), 8'h02);
    check("dack_en", 8'(dack_en), 8'h00);
    tick(1);
    check("delayed_txn", 8'(delayed_txn), 8'h00);
    check("data_grant", 8'(data_grant), 8'h02);
    @(posedge mclk);
    pio_dec <= 2'h0;
    tick(1);
    check("data_grant", 8'(data_grant), 8'h01);
    @(posedge mclk);
    pio_dec <= 2'h1;
    tick(1);
    check("pci_retry", 8'(pci_retry[0]), 8'h01);
    @(posedge mclk);
    pio_dec <= 2'h0;
    dma_cmd <= 2'h0;
    tick(2);
    check("data_grant", 8'(data_grant), 8'h00);
    @(posedge mclk);
    dma_cmd <= 2'h2;
    tick(2);
    check("data_grant", 8'(data_grant), 8'h02);
    @(posedge mclk);
    dma_cmd <= 2'h3;
    tick(2);
    check("data_grant", 8'(data_grant), 8'h02);
    @(posedge mclk);
    dma_cmd <= 2'h1;
    tick(2);
    check("data_grant", 8'(data_grant), 8'h01);
    @(posedge mclk);
    dma_cmd <= 2'h2;
    tick(2);
    check("data_grant", 8'(data_grant), 8'h02);
    @(posedge mclk);
    dma_cmd <= 2'h0;
    pio_dec <= 2'h3;
    tick(1);
    check("addr_grant", 8'(addr_grant), 8'h01);
    check("delayed_txn", 8'(delayed_txn), 8'h01);
    @(posedge mclk);
    pio_dec <= 2'h2;
    fifo_nonempty <= 2'h2;
    tick(1);
    check("pci_retry", 8'(pci_retry), 8'h02);
    check("flush_req", 8'(flush_req), 8'h02);
    @(posedge mclk);
    pio_dec <= 2'h1;
    fifo_nonempty <= 2'h1;
    tick(1);
    check("pci_retry", 8'(pci_retry), 8'h01);
    check("flush_req", 8'(flush_req), 8'h01);
    check("dack_en", 8'(dack_en), 8'h00);
    @(posedge mclk);
    pio_dec <= 2'h0;
    fifo_nonempty <= 2'h0;
    cfg(1'b1, 3'h1, 8'h10, 8'h03);
    tick(2);
    check("ide_reset_n", 8'(ide_reset_n), 8'h00);
    cfg(1'b1, 3'h1, 8'h10, 8'h01);
    @(posedge mclk);
    irq_cmd <= 2'h3;
    tick(3);
    check("ide_reset_n", 8'(ide_reset_n), 8'h01);
    check("isa_irq_out", 8'(isa_irq_out), 8'h0c);
    cfg(1'b1, 3'h0, 8'h4a, 8'h0e);
    tick(2);
    check("isa_irq_out", 8'(isa_irq_out), 8'h03);
    cfg(1'b0, 3'h0, 8'h4a, 8'h0e);
    cfg(1'b1, 3'h1, 8'h09, 8'h05);
    @(posedge mclk);
    isa_irq_in <= r;
    tick(2);
    check("native_irq", 8'(native_irq_source), 8'(r[1:0]));
    cfg(1'b1, 3'h1, 8'h09, 8'h00);
    cfg(1'b1, 3'h1, 8'h10, 8'h00);
    cfg(1'b1, 3'h1, 8'h18, 8'h00);
    tick(2);
    check("isa_irq_out", 8'(isa_irq_out), 8'(r));
    tick(2);
    finish_test();
  end
endmodule
`default_nettype wire
